/* core/pss_pkg.sv */
// Constants of the protection switch selector
package pss_pkg;

    // ----------------------------------------------------------------
    // Request priorities, larger is stronger
    // ----------------------------------------------------------------
    localparam logic [3:0] PRIO_LO = 4'h8;
    localparam logic [3:0] PRIO_FS = 4'h7;
    localparam logic [3:0] PRIO_SF = 4'h6;
    localparam logic [3:0] PRIO_SD = 4'h5;
    localparam logic [3:0] PRIO_MS = 4'h4;
    localparam logic [3:0] PRIO_WTR = 4'h3;
    localparam logic [3:0] PRIO_DNR = 4'h2;
    localparam logic [3:0] PRIO_NR = 4'h1;

    // ----------------------------------------------------------------
    // Defect bit positions
    // ----------------------------------------------------------------
    localparam int DEF_W = 21;
    localparam int D_OTU_LOS = 0;
    localparam int D_OTU_LOF = 1;
    localparam int D_OTU_LOM = 2;
    localparam int D_OTU_AIS = 3;
    localparam int D_ODU_AIS = 4;
    localparam int D_OTU_BSF = 5;
    localparam int D_OTU_BSD = 6;
    localparam int D_SM_TIM = 7;
    localparam int D_PM_TIM = 8;
    localparam int D_SEC_LOF = 9;
    localparam int D_SEC_LOS = 10;
    localparam int D_BER_SF = 11;
    localparam int D_BER_SD = 12;
    localparam int D_LINE_AIS = 13;
    localparam int D_SEC_TIM = 14;
    localparam int D_CARRIER = 15;
    localparam int D_SIG_LOSS = 16;
    localparam int D_TEN_SYNC = 17;
    localparam int D_OOS = 18;
    localparam int D_FC_SYNC = 19;
    localparam int D_CLI_AIS = 20;

    // ----------------------------------------------------------------
    // Trunk payload kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PAY_SONET = 3'h0,
        PAY_SDH = 3'h1,
        PAY_GIGE = 3'h2,
        PAY_FC = 3'h3,
        PAY_TENGIG = 3'h4
    } pss_pay_t;

    // ----------------------------------------------------------------
    // Operator commands; 0 written clears
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_LOCKOUT = 3'h1,
        CMD_FS_TO_PROT = 3'h2,
        CMD_FS_TO_WORK = 3'h3,
        CMD_MS_TO_PROT = 3'h4,
        CMD_MS_TO_WORK = 3'h5
    } pss_cmd_t;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam int ADR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DEFECT = 4'hc;

    // Control fields
    localparam int CTL_G709 = 0;
    localparam int CTL_TIM = 1;
    localparam int CTL_PAY = 2;
    localparam int CTL_YCABLE = 5;
    localparam int CTL_GFP = 6;
    localparam int CTL_BIDIR = 7;
    localparam int CTL_REVERT = 8;
    localparam int CTL_W = 9;
    localparam logic [8:0] CTRL_RST = 9'h001;

    // Status fields
    localparam int ST_SEL = 0;
    localparam int ST_RXW = 1;
    localparam int ST_RXP = 2;
    localparam int ST_BIDIR = 3;
    localparam int ST_PW = 4;
    localparam int ST_PP = 8;
    localparam int ST_CMD = 12;

endpackage

/* core/pss_cond_prio.sv */
// Defect vector to condition priority
`timescale 1ns/10ps
`default_nettype none
module pss_cond_prio
    import pss_pkg::*;
(
    // Defects and provisioning
    input wire logic [DEF_W-1:0] defects,
    input wire logic g709_en,
    input wire logic tim_en,
    input wire pss_pay_t payload,
    input wire logic ycable,
    input wire logic gfp_used,
    // Result
    output logic [3:0] prio
);

    logic sf;
    logic sd;
    logic framed;

    always_comb begin
        framed = (payload == PAY_SONET) || (payload == PAY_SDH);
        sf = 1'b0;
        sd = 1'b0;
        if (g709_en) begin
            sf = defects[D_OTU_LOS] | defects[D_OTU_LOF]
                | defects[D_OTU_LOM] | defects[D_OTU_AIS]
                | defects[D_ODU_AIS] | defects[D_OTU_BSF]
                | defects[D_SM_TIM] | defects[D_PM_TIM];
            sd = defects[D_OTU_BSD];
        end else begin
            if (framed) begin
                // Same defect lines serve OCn and STMn naming
                sf = defects[D_SEC_LOF] | defects[D_SEC_LOS]
                    | defects[D_BER_SF] | defects[D_LINE_AIS];
                sd = defects[D_BER_SD];
            end
            if (tim_en && defects[D_SEC_TIM]) begin
                sf = 1'b1;
            end
            case (payload)
                PAY_GIGE: begin
                    sf = sf | defects[D_CARRIER] | defects[D_OOS];
                end
                PAY_FC: begin
                    sf = sf | defects[D_SIG_LOSS] | defects[D_OOS]
                        | defects[D_FC_SYNC];
                end
                PAY_TENGIG: begin
                    sf = sf | defects[D_TEN_SYNC];
                end
                default: begin
                    sf = sf;
                end
            endcase
        end
        if (ycable && !gfp_used && payload == PAY_SONET
            && defects[D_CLI_AIS]) begin
            sf = 1'b1;
        end
        if (sf) begin
            prio = PRIO_SF;
        end else if (sd) begin
            prio = PRIO_SD;
        end else begin
            prio = PRIO_NR;
        end
    end

endmodule
`default_nettype wire

/* core/pss_selector.sv */
// Protection switch selector
// How it works
// - Priorities one to eight, eight highest
// - Equal above DNR: protect condition wins
// - Select away from highest condition
// - Only SF and SD per channel
// - Receiver enabled before traffic routed
// - Standby transmitter stays enabled
// - Client bridged out, one path in
// - One trunk input, duplicated output
// - OTN defects map to SF, SD
// - SONET defects map to SF, SD
// - SDH defects map to SF, SD
// - J0 mismatch gives SF if enabled
// - Payload losses give SF
// - Client AIS SF with Y-cable on SONET without GFP
// - Lockout on protect port
// - Forced request on named port
// - Manual request on named port
// - Clear cancels held command
// - Unidirectional ignores far-end state
// - Bidirectional needs intact trunk, live peer
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module pss_selector
    import pss_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Trunk defects
    input wire logic [DEF_W-1:0] work_defects,
    input wire logic [DEF_W-1:0] prot_defects,
    // Far-end group
    input wire logic far_card_oper,
    input wire logic [3:0] far_req_prio,
    input wire logic far_req_on_prot,
    output logic [3:0] near_req_prio,
    output logic near_req_on_prot,
    // Trunk optics control
    output logic work_rx_enable,
    output logic prot_rx_enable,
    output logic work_tx_enable,
    output logic prot_tx_enable,
    output logic active_prot,
    // Traffic
    input wire logic [DATA_W-1:0] client_rx_data,
    input wire logic [DATA_W-1:0] work_rx_data,
    input wire logic [DATA_W-1:0] prot_rx_data,
    output logic [DATA_W-1:0] client_tx_data,
    output logic [DATA_W-1:0] work_tx_data,
    output logic [DATA_W-1:0] prot_tx_data
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 1 and 32");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [CTL_W-1:0] ctrl;
        pss_cmd_t cmd;
        logic [DEF_W-1:0] def_w;
        logic [DEF_W-1:0] def_p;
        logic far_oper;
        logic [3:0] far_prio;
        logic far_prot;
        logic [3:0] prio_w;
        logic [3:0] prio_p;
        logic bidir;
        logic sel;
        logic route;
        logic rx_w;
        logic rx_p;
        logic [3:0] near_prio;
        logic near_prot;
        logic [DATA_W-1:0] cli_tx;
        logic [DATA_W-1:0] trk_tx;
    } pss_state_t;

    pss_state_t s_q;
    pss_state_t s_d;

    // ----------------------------------------------------------------
    // Condition mapping per trunk
    // ----------------------------------------------------------------
    logic [3:0] cond_w;
    logic [3:0] cond_p;
    pss_pay_t pay;

    assign pay = pss_pay_t'(s_q.ctrl[CTL_PAY+:3]);

    pss_cond_prio u_cond_w (
        .defects(s_q.def_w),
        .g709_en(s_q.ctrl[CTL_G709]),
        .tim_en(s_q.ctrl[CTL_TIM]),
        .payload(pay),
        .ycable(s_q.ctrl[CTL_YCABLE]),
        .gfp_used(s_q.ctrl[CTL_GFP]),
        .prio(cond_w)
    );

    pss_cond_prio u_cond_p (
        .defects(s_q.def_p),
        .g709_en(s_q.ctrl[CTL_G709]),
        .tim_en(s_q.ctrl[CTL_TIM]),
        .payload(pay),
        .ycable(s_q.ctrl[CTL_YCABLE]),
        .gfp_used(s_q.ctrl[CTL_GFP]),
        .prio(cond_p)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic acc;
    logic [3:0] cmd_w;
    logic [3:0] cmd_p;
    logic [3:0] pw;
    logic [3:0] pp;
    logic [3:0] held_prio;
    logic [3:0] new_prio;
    logic tgt;
    logic intact;
    pss_cmd_t new_cmd;

    always_comb begin
        s_d = s_q;
        acc = wb_cyc_i && wb_stb_i && !s_q.ack;
        new_cmd = pss_cmd_t'(wb_dat_i[2:0]);
        cmd_w = PRIO_NR;
        cmd_p = PRIO_NR;
        held_prio = PRIO_NR;
        new_prio = PRIO_NR;
        tgt = s_q.sel;

        // Inputs are registered before any decision
        s_d.def_w = work_defects;
        s_d.def_p = prot_defects;
        s_d.far_oper = far_card_oper;
        s_d.far_prio = far_req_prio;
        s_d.far_prot = far_req_on_prot;

        // Command priority, placed on one port for the whole group
        case (s_q.cmd)
            CMD_LOCKOUT: begin
                cmd_p = PRIO_LO;
                held_prio = PRIO_LO;
            end
            CMD_FS_TO_PROT: begin
                cmd_w = PRIO_FS;
                held_prio = PRIO_FS;
            end
            CMD_FS_TO_WORK: begin
                cmd_p = PRIO_FS;
                held_prio = PRIO_FS;
            end
            CMD_MS_TO_PROT: begin
                cmd_w = PRIO_MS;
                held_prio = PRIO_MS;
            end
            CMD_MS_TO_WORK: begin
                cmd_p = PRIO_MS;
                held_prio = PRIO_MS;
            end
            default: begin
                held_prio = PRIO_NR;
            end
        endcase

        // Bus access; a weaker command never displaces a stronger one
        s_d.ack = acc;
        s_d.rdata = 32'h0;
        if (acc && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    s_d.ctrl[7:0] = wb_dat_i[7:0];
                end
                REG_CMD: begin
                    case (new_cmd)
                        CMD_LOCKOUT: new_prio = PRIO_LO;
                        CMD_FS_TO_PROT: new_prio = PRIO_FS;
                        CMD_FS_TO_WORK: new_prio = PRIO_FS;
                        CMD_MS_TO_PROT: new_prio = PRIO_MS;
                        CMD_MS_TO_WORK: new_prio = PRIO_MS;
                        default: new_prio = PRIO_NR;
                    endcase
                    if (new_cmd == CMD_NONE) begin
                        s_d.cmd = CMD_NONE;
                    end else if (new_prio != PRIO_NR
                        && new_prio >= held_prio) begin
                        s_d.cmd = new_cmd;
                    end
                end
                default: begin
                    s_d.ctrl = s_q.ctrl;
                end
            endcase
        end
        if (acc && wb_we_i && wb_sel_i[1] && wb_adr_i == REG_CTRL) begin
            s_d.ctrl[CTL_W-1:8] = wb_dat_i[CTL_W-1:8];
        end
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    s_d.rdata[CTL_W-1:0] = s_q.ctrl;
                end
                REG_CMD: begin
                    s_d.rdata[2:0] = s_q.cmd;
                end
                REG_STAT: begin
                    s_d.rdata[ST_SEL] = s_q.sel;
                    s_d.rdata[ST_RXW] = s_q.rx_w;
                    s_d.rdata[ST_RXP] = s_q.rx_p;
                    s_d.rdata[ST_BIDIR] = s_q.bidir;
                    s_d.rdata[ST_PW+:4] = s_q.prio_w;
                    s_d.rdata[ST_PP+:4] = s_q.prio_p;
                    s_d.rdata[ST_CMD+:3] = s_q.cmd;
                end
                REG_DEFECT: begin
                    s_d.rdata[3:0] = cond_w;
                    s_d.rdata[7:4] = cond_p;
                end
                default: begin
                    s_d.rdata = 32'h0;
                end
            endcase
        end

        // Only SF and SD are per channel; commands sit on one port
        pw = (cmd_w > cond_w) ? cmd_w : cond_w;
        pp = (cmd_p > cond_p) ? cmd_p : cond_p;

        // Far-end requests count only with an intact trunk and peer
        intact = (cond_w < PRIO_SD) || (cond_p < PRIO_SD);
        s_d.bidir = s_q.ctrl[CTL_BIDIR] && intact
            && s_q.far_oper;
        if (s_q.bidir) begin
            if (s_q.far_prot && s_q.far_prio > pp) begin
                pp = s_q.far_prio;
            end
            if (!s_q.far_prot && s_q.far_prio > pw) begin
                pw = s_q.far_prio;
            end
        end
        // Unidirectional: far-end state never enters the choice
        s_d.prio_w = pw;
        s_d.prio_p = pp;

        // Advertise the stronger request, far-end requests included when bidirectional, to the peer
        if (pp >= pw) begin
            s_d.near_prio = pp;
            s_d.near_prot = 1'b1;
        end else begin
            s_d.near_prio = pw;
            s_d.near_prot = 1'b0;
        end

        // Switch away from the highest condition
        if (s_q.prio_w > s_q.prio_p) begin
            tgt = 1'b1;
        end else if (s_q.prio_p > s_q.prio_w) begin
            tgt = 1'b0;
        end else if (s_q.prio_p > PRIO_DNR) begin
            tgt = 1'b0;
        end else if (s_q.ctrl[CTL_REVERT]) begin
            tgt = 1'b0;
        end else begin
            tgt = s_q.sel;
        end

        // Receiver first, then route, then drop the old receiver
        if (tgt != s_q.sel) begin
            s_d.sel = tgt;
            if (tgt) begin
                s_d.rx_p = 1'b1;
            end else begin
                s_d.rx_w = 1'b1;
            end
        end else if (s_q.route != s_q.sel) begin
            s_d.route = s_q.sel;
        end else begin
            s_d.rx_w = !s_q.sel;
            s_d.rx_p = s_q.sel;
        end

        // Traffic: bridge out, one path in
        s_d.trk_tx = client_rx_data;
        s_d.cli_tx = s_q.route ? prot_rx_data : work_rx_data;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h0;
            s_q.ctrl <= CTRL_RST;
            s_q.cmd <= CMD_NONE;
            s_q.def_w <= '0;
            s_q.def_p <= '0;
            s_q.far_oper <= 1'b0;
            s_q.far_prio <= PRIO_NR;
            s_q.far_prot <= 1'b0;
            s_q.prio_w <= PRIO_NR;
            s_q.prio_p <= PRIO_NR;
            s_q.bidir <= 1'b0;
            s_q.sel <= 1'b0;
            s_q.route <= 1'b0;
            s_q.rx_w <= 1'b1;
            s_q.rx_p <= 1'b0;
            s_q.near_prio <= PRIO_NR;
            s_q.near_prot <= 1'b0;
            s_q.cli_tx <= '0;
            s_q.trk_tx <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Switching must never silence the standby laser
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            work_tx_enable <= 1'b1;
            prot_tx_enable <= 1'b1;
        end else begin
            work_tx_enable <= 1'b1;
            prot_tx_enable <= 1'b1;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign near_req_prio = s_q.near_prio;
    assign near_req_on_prot = s_q.near_prot;
    assign work_rx_enable = s_q.rx_w;
    assign prot_rx_enable = s_q.rx_p;
    assign active_prot = s_q.route;
    assign client_tx_data = s_q.cli_tx;
    // One transmitter, split onto both trunk ports
    assign work_tx_data = s_q.trk_tx;
    assign prot_tx_data = s_q.trk_tx;

endmodule
`default_nettype wire

/* tb/pss_selector_chk.sv */
// Port checker for the protection switch selector
`timescale 1ns/10ps
`default_nettype none
module pss_selector_chk
    import pss_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // Clock, reset and bus
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Switch state
    input wire logic [3:0] near_req_prio,
    input wire logic work_rx_enable,
    input wire logic prot_rx_enable,
    input wire logic work_tx_enable,
    input wire logic prot_tx_enable,
    input wire logic active_prot,
    // Traffic
    input wire logic [DATA_W-1:0] client_rx_data,
    input wire logic [DATA_W-1:0] work_rx_data,
    input wire logic [DATA_W-1:0] prot_rx_data,
    input wire logic [DATA_W-1:0] client_tx_data,
    input wire logic [DATA_W-1:0] work_tx_data,
    input wire logic [DATA_W-1:0] prot_tx_data
);
    // ----------------------------------------------------------------
    // Helper registers
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] route_q, cli_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            route_q <= '0;
            cli_q <= '0;
        end else begin
            route_q <= active_prot ? prot_rx_data : work_rx_data;
            cli_q <= client_rx_data;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Old receiver goes dark only after the route has moved
    sequence to_prot_s;
        $rose(active_prot) ##1 !work_rx_enable;
    endsequence
    sequence to_work_s;
        $fell(active_prot) ##1 !prot_rx_enable;
    endsequence

    tx_always_on_a: assert property (work_tx_enable && prot_tx_enable)
        else $error("trunk tx off");
    rx_before_route_a: assert property (
        $rose(prot_rx_enable) |=> to_prot_s) else $error("order to protect");
    rx_back_route_a: assert property (
        $rose(work_rx_enable) |=> to_work_s) else $error("order to working");
    active_rx_on_a: assert property (
        active_prot ? prot_rx_enable : work_rx_enable) else $error("rx off");
    one_path_rx_a: assert property (
        client_tx_data == route_q) else $error("client tx wrong");
    bridge_tx_a: assert property (
        work_tx_data == cli_q && prot_tx_data == cli_q) else $error("bridge");
    prio_range_a: assert property (
        near_req_prio inside {[PRIO_NR:PRIO_LO]}) else $error("bad prio");
    reset_state_a: assert property (disable iff (1'b0) reset |->
        work_rx_enable && !prot_rx_enable && !active_prot
        && near_req_prio == PRIO_NR) else $error("reset state wrong");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
endmodule

bind pss_selector pss_selector_chk #(.DATA_W(DATA_W)) pss_selector_chk_inst (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .near_req_prio(near_req_prio),
    .work_rx_enable(work_rx_enable), .prot_rx_enable(prot_rx_enable),
    .work_tx_enable(work_tx_enable), .prot_tx_enable(prot_tx_enable),
    .active_prot(active_prot), .client_rx_data(client_rx_data),
    .work_rx_data(work_rx_data), .prot_rx_data(prot_rx_data),
    .client_tx_data(client_tx_data), .work_tx_data(work_tx_data),
    .prot_tx_data(prot_tx_data));
`default_nettype wire

/* tb/pss_far_end.sv */
// Model of the far-end protection group
`timescale 1ns/10ps
`default_nettype none
module pss_far_end
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Peer state chosen by the bench
    input wire logic oper_set,
    input wire logic [3:0] prio_set,
    input wire logic on_prot_set,
    // Towards the near end
    output logic far_card_oper,
    output logic [3:0] far_req_prio,
    output logic far_req_on_prot
);
    // A dead peer card reports rubbish
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            far_card_oper <= 1'b0;
            far_req_prio <= PRIO_NR;
            far_req_on_prot <= 1'b0;
        end else begin
            far_card_oper <= oper_set;
            far_req_prio <= oper_set ? prio_set : ~far_req_prio;
            far_req_on_prot <= oper_set ? on_prot_set : ~far_req_on_prot;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the protection switch selector
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pss_pkg::*;
;
    logic clk = 1'b0, reset, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0] adr = 4'h0, sel = 4'hf, fprio = 4'h1, far_prio, near_prio, pr;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic [20:0] wdef = 21'h0, pdef = 21'h0;
    logic oper = 1'b0, fon = 1'b0, far_oper, far_on, side;
    logic [7:0] cli = 8'h0, wrx = 8'h0, prx = 8'h0;
    logic [31:0] exp_q[$], msk_q[$];
    int mismatches = 0, tests_run = 0, cycles = 0;
    integer seed = 32'h54aa60b2;
    // Control, defect bit, expected condition priority
    logic [23:0] tbl [0:31] = '{24'h001006, 24'h001016, 24'h001026,
        24'h001036, 24'h001046, 24'h001056, 24'h001065, 24'h001076,
        24'h001086, 24'h001091, 24'h000096, 24'h0000a6, 24'h0000b6,
        24'h0000c5, 24'h0000d6, 24'h000001, 24'h004096, 24'h0040a6,
        24'h0040b6, 24'h0040c5, 24'h0040d6, 24'h0020e6, 24'h0000e1,
        24'h0080f6, 24'h008126, 24'h008131, 24'h00c106, 24'h00c126,
        24'h00c136, 24'h010116, 24'h020146, 24'h060141};

    always #20 clk = ~clk;

    pss_selector pss_selector_inst (.clk(clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .work_defects(wdef), .prot_defects(pdef), .far_card_oper(far_oper),
        .far_req_prio(far_prio), .far_req_on_prot(far_on),
        .near_req_prio(near_prio), .near_req_on_prot(),
        .work_rx_enable(), .prot_rx_enable(), .work_tx_enable(),
        .prot_tx_enable(), .active_prot(), .client_rx_data(cli),
        .work_rx_data(wrx), .prot_rx_data(prx), .client_tx_data(),
        .work_tx_data(), .prot_tx_data());

    pss_far_end pss_far_end_inst (.clk(clk), .reset(reset), .oper_set(oper),
        .prio_set(fprio), .on_prot_set(fon), .far_card_oper(far_oper),
        .far_req_prio(far_prio), .far_req_on_prot(far_on));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] st(input logic s, input logic [3:0] pw, pp,
        input logic [2:0] c);
        return {17'h0, c, pp, pw, 3'h0, s};
    endfunction

    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask

    // Condition chain needs four cycles; six leaves margin
    task automatic trunks(input logic [20:0] w, p);
        @(posedge clk);
        wdef <= w;
        pdef <= p;
        repeat (6) @(posedge clk);
    endtask

    task automatic cmd(input logic [2:0] c);
        bus(1'b1, REG_CMD, {29'h0, c});
        repeat (6) @(posedge clk);
    endtask

    task automatic check(input logic [31:0] got, e, m);
        tests_run++;
        if ((got & m) !== (e & m)) begin
            mismatches++;
            $display("[FAIL] %0t read %h expected %h", $time, got, e);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Random traffic, read observer and timeout
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        {cli, wrx, prx} <= 24'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict;
        end
    end

    always @(posedge clk) begin
        if (ack === 1'b1 && !we) begin
            if (exp_q.size() == 0)
                check(dat_r, 32'hdead, 32'hffffffff);
            else
                check(dat_r, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(REG_CTRL, 32'h1, 32'h1ff);
        rd(REG_CMD, 32'h0, 32'h7);
        rd(REG_STAT, st(0, PRIO_NR, PRIO_NR, 0) | 32'h2, 32'h7ff7);
        bus(1'b1, 4'h6, 32'h1fe);
        rd(4'h2, 32'h0, 32'hffffffff);
        rd(REG_CTRL, 32'h1, 32'h1ff);
        for (int i = 0; i < 32; i++) begin
            side = 1'($random(seed));
            pr = tbl[i][3:0];
            bus(1'b1, REG_CTRL, {20'h0, tbl[i][23:12]});
            if (side)
                trunks(21'h0, 21'h1 << tbl[i][11:4]);
            else
                trunks(21'h1 << tbl[i][11:4], 21'h0);
            rd(REG_DEFECT, side ? {pr, 4'h1} : {4'h1, pr}, 32'hff);
        end
        bus(1'b1, REG_CTRL, 32'h1);
        trunks(21'h1, 21'h0);
        rd(REG_STAT, 32'h1, 32'h1);
        trunks(21'h1, 21'h1);
        rd(REG_STAT, st(0, PRIO_SF, PRIO_SF, 0), 32'hff1);
        trunks(21'h1, 21'h40);
        rd(REG_STAT, 32'h1, 32'h1);
        trunks(21'h40, 21'h40);
        rd(REG_STAT, 32'h0, 32'h1);
        trunks(21'h0, 21'h0);
        cmd(CMD_LOCKOUT);
        rd(REG_STAT, st(0, PRIO_NR, PRIO_LO, 1), 32'h7ff1);
        trunks(21'h1, 21'h0);
        rd(REG_STAT, st(0, PRIO_SF, PRIO_LO, 1), 32'h7ff1);
        cmd(CMD_FS_TO_PROT);
        rd(REG_CMD, 32'h1, 32'h7);
        cmd(CMD_NONE);
        rd(REG_STAT, st(1, PRIO_SF, PRIO_NR, 0), 32'h7ff1);
        trunks(21'h0, 21'h0);
        for (int k = 0; k < 4; k++) begin
            pr = (k < 2) ? PRIO_FS : PRIO_MS;
            cmd(3'(k + 2));
            rd(REG_STAT, st(!k[0], k[0] ? PRIO_NR : pr, k[0] ? pr : PRIO_NR,
                3'(k + 2)), 32'h7ff1);
            cmd(CMD_NONE);
        end
        cmd(3'h6);
        rd(REG_CMD, 32'h0, 32'h7);
        @(posedge clk);
        oper <= 1'b1;
        fprio <= PRIO_SF;
        trunks(21'h0, 21'h0);
        rd(REG_STAT, 32'h0, 32'h1);
        oper <= 1'b0;
        bus(1'b1, REG_CTRL, 32'h81);
        trunks(21'h0, 21'h0);
        rd(REG_STAT, 32'h0, 32'h1);
        oper <= 1'b1;
        trunks(21'h0, 21'h0);
        rd(REG_STAT, 32'h1, 32'h1);
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0)
            mismatches++;
        print_verdict;
    end
endmodule
`default_nettype wire
